/* logic/trig_ctrl_pkg.sv */
/*
  trig_ctrl_pkg: register offsets, field positions, reset values, selector codes
  and timing counts shared by the trigger/command control logic.
  Assumes a 32-bit APB register bus and a 100 MHz module clock.
*/
package trig_ctrl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TRIG = 4;
  localparam int unsigned NUM_CMD  = 8;
  localparam int unsigned NUM_CHAN = 20;
  localparam int unsigned SEL_W    = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFS     = 12'h000;
  localparam logic [11:0] STATUS_OFFS   = 12'h004;
  localparam logic [11:0] SOFTTRIG_OFFS = 12'h008;
  localparam logic [11:0] CALAVG_OFFS   = 12'h00C;
  localparam logic [11:0] TSEL_OFFS     = 12'h010;
  localparam logic [11:0] TCTRL_OFFS    = 12'h020;  // four words, one per trigger
  localparam logic [11:0] CMD_OFFS      = 12'h040;  // eight words, one per command

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_HALT_BIT    = 1;  // sleep_halt_enable
  localparam int unsigned CTRL_PREEN_BIT   = 2;
  localparam int unsigned CTRL_CAL_BIT     = 3;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // trigger_control fields
  // ----------------------------------------------------------------
  localparam int unsigned TC_HWEN_BIT  = 0;
  localparam int unsigned TC_PRI_LSB   = 8;
  localparam int unsigned TC_PRI_W     = 2;
  localparam int unsigned TC_CMD_LSB   = 16;
  localparam int unsigned TC_CMD_W     = 3;

  // ----------------------------------------------------------------
  // command fields
  // ----------------------------------------------------------------
  localparam int unsigned CMD_CHAN_LSB = 0;
  localparam int unsigned CMD_CHAN_W   = 5;
  localparam int unsigned CMD_SIDEB_BIT = 8;
  localparam int unsigned CMD_DIFF_BIT  = 9;
  localparam int unsigned CMD_HIRES_BIT = 10;
  localparam int unsigned CMD_DUAL_BIT  = 11;

  // ----------------------------------------------------------------
  // resolutions
  // ----------------------------------------------------------------
  localparam logic [4:0] RES_HIGH      = 5'h10;  // 16 bits
  localparam logic [4:0] RES_DIFF_LOW  = 5'h0D;  // 13 bits
  localparam logic [4:0] RES_SE_LOW    = 5'h0C;  // 12 bits

  // ----------------------------------------------------------------
  // trigger selector codes for timer match channel 3
  // ----------------------------------------------------------------
  localparam logic [5:0] SEL_TIMER0 = 6'h05;
  localparam logic [5:0] SEL_TIMER1 = 6'h06;
  localparam logic [5:0] SEL_TIMER2 = 6'h07;
  localparam logic [5:0] SEL_TIMER3 = 6'h08;
  localparam logic [5:0] SEL_TIMER4 = 6'h09;

  // ----------------------------------------------------------------
  // calibration and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  CAL_AVG_RESET  = 8'h80;  // 128 samples
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned STARTUP_NS     = 1000;
  localparam int unsigned STARTUP_CYC    = (STARTUP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STARTUP,
    ST_CONVERT
  } conv_state_e;

endpackage : trig_ctrl_pkg

/* logic/conv_req_if.sv */
/*
  conv_req_if: request/answer bundle between the trigger arbiter and
  the conversion sequencer. Both ends run on the same module clock.
*/
interface conv_req_if;
  logic       valid;
  logic       ready;
  logic [2:0] cmd;
  logic [1:0] trig;

  modport arb (output valid, output cmd, output trig, input ready);
  modport seq (input valid, input cmd, input trig, output ready);
endinterface : conv_req_if

/* logic/trig_arbiter.sv */
/*
  trig_arbiter: keeps pending trigger events and offers the one with the
  highest priority to the sequencer. Assumes events arrive as one-cycle
  pulses on the module clock.
*/
module trig_arbiter (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  // events and trigger settings
  input  wire logic [3:0]          event_i,
  input  wire logic [3:0][1:0]     priority_i,
  input  wire logic [3:0][2:0]     cmd_sel_i,
  // request to sequencer
  conv_req_if.arb                  req,
  // pending view
  output logic [3:0]               pending_o
);

  logic [3:0] pending;
  logic [3:0] next_pending;
  logic [1:0] win;
  logic       any;

  // pick highest priority; lower index breaks ties
  always_comb begin
    win = 2'h0;
    any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (pending[i] && (!any || priority_i[i] > priority_i[win])) begin
        win = 2'(i);
        any = 1'b1;
      end
    end
  end

  // set wins over the served clear so a fresh event is never lost
  always_comb begin
    next_pending = pending;
    if (req.valid && req.ready) begin
      next_pending[win] = 1'b0;
    end
    next_pending = next_pending | event_i;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending <= 4'h0;
    end else begin
      pending <= next_pending;
    end
  end

  assign req.valid = any;
  assign req.trig  = win;
  assign req.cmd   = cmd_sel_i[win];
  assign pending_o = pending;

endmodule : trig_arbiter

/* logic/adc_trigger_command_control.sv */
/*
  adc_trigger_command_control: trigger selection, arbitration, command
  decoding, low-power handling and calibration averaging of a dual
  converter. Registers sit on APB. Hardware trigger sources are
  asynchronous; the analog core answers with a one-cycle done pulse per conversion.
*/
// Register access over APB and the placing of the registers were left to the implementer.
module adc_trigger_command_control (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // asynchronous timer match channel 3 outputs, timer 0..4
  input  wire logic [4:0]  timer_match_ch3_i,
  // power management
  input  wire logic        sleep_i,
  input  wire logic        clk_runs_in_sleep_i,
  input  wire logic        pd_req_i,
  output logic             pd_ack_o,
  // analog core
  output logic             conv_start_o,
  output logic [4:0]       conv_chan_o,
  output logic             conv_side_b_o,
  output logic             conv_diff_o,
  output logic             conv_dual_o,
  output logic [4:0]       conv_res_o,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_data_i,
  // calibration result
  output logic [15:0]      cal_value_o,
  output logic             cal_busy_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]      ctrl;
  logic [7:0]       cal_avg;
  logic [3:0][5:0]  tsel;
  logic [3:0][31:0] tctrl;
  logic [7:0][11:0] cmd_word;
  logic [3:0]       soft_trig;
  logic [31:0]      next_ctrl;
  logic [7:0]       next_cal_avg;
  logic [3:0][5:0]  next_tsel;
  logic [3:0][31:0] next_tctrl;
  logic [7:0][11:0] next_cmd_word;
  logic [3:0]       next_soft_trig;
  logic             wr_en;
  logic             rd_hit;
  logic [31:0]      rd_data;

  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign pready_o  = 1'b1;  // zero wait states
  assign pslverr_o = psel_i && penable_i && !rd_hit;

  // word index inside a bank
  function automatic logic [2:0] bank_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[4:2];
  endfunction : bank_idx

  // register write next-state
  always_comb begin
    next_ctrl      = ctrl;
    next_cal_avg   = cal_avg;
    next_tsel      = tsel;
    next_tctrl     = tctrl;
    next_cmd_word  = cmd_word;
    next_soft_trig = 4'h0;  // soft trigger bits are write-one pulses
    if (wr_en) begin
      if (paddr_i == trig_ctrl_pkg::CTRL_OFFS) begin
        next_ctrl = pwdata_i;
      end else if (paddr_i == trig_ctrl_pkg::SOFTTRIG_OFFS) begin
        next_soft_trig = pwdata_i[3:0];
      end else if (paddr_i == trig_ctrl_pkg::CALAVG_OFFS) begin
        next_cal_avg = pwdata_i[7:0];
      end else if (paddr_i == trig_ctrl_pkg::TSEL_OFFS) begin
        for (int i = 0; i < 4; i++) begin
          next_tsel[i] = pwdata_i[8*i +: 6];
        end
      end else if (paddr_i[11:4] == trig_ctrl_pkg::TCTRL_OFFS[11:4]) begin
        next_tctrl[bank_idx(paddr_i, trig_ctrl_pkg::TCTRL_OFFS)] = pwdata_i;
      end else if (paddr_i[11:5] == trig_ctrl_pkg::CMD_OFFS[11:5]) begin
        next_cmd_word[bank_idx(paddr_i, trig_ctrl_pkg::CMD_OFFS)] = pwdata_i[11:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl      <= trig_ctrl_pkg::CTRL_RESET;
      cal_avg   <= trig_ctrl_pkg::CAL_AVG_RESET;
      tsel      <= '0;
      tctrl     <= '0;
      cmd_word  <= '0;
      soft_trig <= 4'h0;
    end else begin
      ctrl      <= next_ctrl;
      cal_avg   <= next_cal_avg;
      tsel      <= next_tsel;
      tctrl     <= next_tctrl;
      cmd_word  <= next_cmd_word;
      soft_trig <= next_soft_trig;
    end
  end

  // ----------------------------------------------------------------
  // hardware trigger sync, select, edge
  // ----------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [3:0] hw_lvl;
  logic [3:0] hw_lvl_q;
  logic [3:0] trig_event;

  // two flops before any logic reads the timer lines
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= timer_match_ch3_i;
      sync2 <= sync1;
    end
  end

  // selector decode; unknown codes hold the trigger low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (tsel[i])
        trig_ctrl_pkg::SEL_TIMER0: hw_lvl[i] = sync2[0];
        trig_ctrl_pkg::SEL_TIMER1: hw_lvl[i] = sync2[1];
        trig_ctrl_pkg::SEL_TIMER2: hw_lvl[i] = sync2[2];
        trig_ctrl_pkg::SEL_TIMER3: hw_lvl[i] = sync2[3];
        trig_ctrl_pkg::SEL_TIMER4: hw_lvl[i] = sync2[4];
        default:                   hw_lvl[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hw_lvl_q <= 4'h0;
    end else begin
      hw_lvl_q <= hw_lvl;
    end
  end

  // events are gated off while the block is disabled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      trig_event[i] = ctrl[trig_ctrl_pkg::CTRL_ENABLE_BIT] &&
                      (soft_trig[i] ||
                       (tctrl[i][trig_ctrl_pkg::TC_HWEN_BIT] &&
                        hw_lvl[i] && !hw_lvl_q[i]));
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  conv_req_if       req ();
  logic [3:0][1:0]  pri;
  logic [3:0][2:0]  csel;
  logic [3:0]       pending;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pri[i]  = tctrl[i][trig_ctrl_pkg::TC_PRI_LSB +: trig_ctrl_pkg::TC_PRI_W];
      csel[i] = tctrl[i][trig_ctrl_pkg::TC_CMD_LSB +: trig_ctrl_pkg::TC_CMD_W];
    end
  end

  trig_arbiter arb (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .event_i    (trig_event),
    .priority_i (pri),
    .cmd_sel_i  (csel),
    .req        (req.arb),
    .pending_o  (pending)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  trig_ctrl_pkg::conv_state_e state;
  trig_ctrl_pkg::conv_state_e next_state;
  logic [7:0]  wait_cnt;
  logic [7:0]  next_wait_cnt;
  logic [11:0] cur_cmd;
  logic [11:0] next_cur_cmd;
  logic        start;
  logic        next_start;
  logic        halted;

  // sleep pauses new starts unless halt enable is clear and clock keeps going
  assign halted = pd_req_i || (sleep_i && (ctrl[trig_ctrl_pkg::CTRL_HALT_BIT] ||
                                            !clk_runs_in_sleep_i));
  assign req.ready = (state == trig_ctrl_pkg::ST_IDLE) && !halted;

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    next_cur_cmd  = cur_cmd;
    next_start    = 1'b0;
    unique case (state)
      trig_ctrl_pkg::ST_IDLE: begin
        if (req.valid && req.ready) begin
          next_cur_cmd = cmd_word[req.cmd];
          if (ctrl[trig_ctrl_pkg::CTRL_PREEN_BIT]) begin
            next_start = 1'b1;
            next_state = trig_ctrl_pkg::ST_CONVERT;
          end else begin
            next_wait_cnt = 8'(trig_ctrl_pkg::STARTUP_CYC - 1);
            next_state    = trig_ctrl_pkg::ST_STARTUP;
          end
        end
      end
      trig_ctrl_pkg::ST_STARTUP: begin
        if (wait_cnt == 8'h00) begin
          next_start = 1'b1;
          next_state = trig_ctrl_pkg::ST_CONVERT;
        end else begin
          next_wait_cnt = wait_cnt - 8'h01;
        end
      end
      trig_ctrl_pkg::ST_CONVERT: begin
        if (conv_done_i) begin
          next_state = trig_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= trig_ctrl_pkg::ST_IDLE;
      wait_cnt <= 8'h00;
      cur_cmd  <= 12'h000;
      start    <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      cur_cmd  <= next_cur_cmd;
      start    <= next_start;
    end
  end

  // power-down acknowledged only once idle, never mid conversion
  assign pd_ack_o = pd_req_i && (state == trig_ctrl_pkg::ST_IDLE);

  // command decode toward the analog core
  logic [4:0] chan;
  assign chan          = cur_cmd[trig_ctrl_pkg::CMD_CHAN_LSB +: trig_ctrl_pkg::CMD_CHAN_W];
  assign conv_start_o  = start;
  assign conv_chan_o   = (chan < 5'(trig_ctrl_pkg::NUM_CHAN)) ? chan : 5'h00;
  assign conv_side_b_o = cur_cmd[trig_ctrl_pkg::CMD_SIDEB_BIT];
  assign conv_diff_o   = cur_cmd[trig_ctrl_pkg::CMD_DIFF_BIT];
  // dual sampling only makes sense for single-ended pairs
  assign conv_dual_o   = cur_cmd[trig_ctrl_pkg::CMD_DUAL_BIT] &&
                         !cur_cmd[trig_ctrl_pkg::CMD_DIFF_BIT];
  assign conv_res_o    = cur_cmd[trig_ctrl_pkg::CMD_HIRES_BIT] ? trig_ctrl_pkg::RES_HIGH :
                         cur_cmd[trig_ctrl_pkg::CMD_DIFF_BIT]  ? trig_ctrl_pkg::RES_DIFF_LOW :
                                                                 trig_ctrl_pkg::RES_SE_LOW;

  // ----------------------------------------------------------------
  // calibration averaging
  // ----------------------------------------------------------------
  logic        cal_done_pulse;
  calib_avg cal (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .cal_en_i    (ctrl[trig_ctrl_pkg::CTRL_CAL_BIT]),
    .count_i     (cal_avg),
    .sample_i    (conv_done_i && state == trig_ctrl_pkg::ST_CONVERT),
    .data_i      (conv_data_i),
    .value_o     (cal_value_o),
    .busy_o      (cal_busy_o),
    .done_o      (cal_done_pulse)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr_i == trig_ctrl_pkg::CTRL_OFFS) begin
      rd_data = ctrl;
    end else if (paddr_i == trig_ctrl_pkg::STATUS_OFFS) begin
      rd_data = {22'h0, cal_done_pulse, cal_busy_o, pending, 2'(state), pd_ack_o, halted};
    end else if (paddr_i == trig_ctrl_pkg::SOFTTRIG_OFFS) begin
      rd_data = 32'h0000_0000;
    end else if (paddr_i == trig_ctrl_pkg::CALAVG_OFFS) begin
      rd_data = {24'h0, cal_avg};
    end else if (paddr_i == trig_ctrl_pkg::TSEL_OFFS) begin
      rd_data = {2'h0, tsel[3], 2'h0, tsel[2], 2'h0, tsel[1], 2'h0, tsel[0]};
    end else if (paddr_i[11:4] == trig_ctrl_pkg::TCTRL_OFFS[11:4]) begin
      rd_data = tctrl[bank_idx(paddr_i, trig_ctrl_pkg::TCTRL_OFFS)];
    end else if (paddr_i[11:5] == trig_ctrl_pkg::CMD_OFFS[11:5]) begin
      rd_data = {20'h0, cmd_word[bank_idx(paddr_i, trig_ctrl_pkg::CMD_OFFS)]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    prdata_o = (psel_i && !pwrite_i) ? rd_data : 32'h0000_0000;
  end

endmodule : adc_trigger_command_control

/* logic/calib_avg.sv */
/*
  calib_avg: accumulates a programmable number of conversion results and
  divides to one calibration value. Count is rounded down to a power of two.
*/
module calib_avg (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        cal_en_i,
  input  wire logic [7:0]  count_i,
  // samples
  input  wire logic        sample_i,
  input  wire logic [15:0] data_i,
  // result
  output logic [15:0]      value_o,
  output logic             busy_o,
  output logic             done_o
);

  logic [23:0] acc;
  logic [23:0] next_acc;
  logic [7:0]  n;
  logic [7:0]  next_n;
  logic [15:0] value;
  logic [15:0] next_value;
  logic        busy;
  logic        next_busy;
  logic        done;
  logic        next_done;
  logic [2:0]  sh;

  // log2 of count; power-of-two counts keep the divider a shift
  always_comb begin
    sh = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (count_i[i]) begin
        sh = 3'(i);
      end
    end
  end

  always_comb begin
    next_acc   = acc;
    next_n     = n;
    next_value = value;
    next_busy  = busy;
    next_done  = 1'b0;
    if (!busy) begin
      if (cal_en_i) begin
        next_busy = 1'b1;
        next_acc  = 24'h0;
        next_n    = 8'h00;
      end
    end else if (sample_i) begin
      next_acc = acc + {8'h0, data_i};
      next_n   = n + 8'h01;
      if ((n + 8'h01) >= (8'h01 << sh)) begin
        next_value = 16'((acc + {8'h0, data_i}) >> sh);
        next_busy  = 1'b0;
        next_done  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc   <= 24'h0;
      n     <= 8'h00;
      value <= 16'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      acc   <= next_acc;
      n     <= next_n;
      value <= next_value;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  assign value_o = value;
  assign busy_o  = busy;
  assign done_o  = done;

endmodule : calib_avg

/* verif/conv_core_model.sv */
/*
  conv_core_model: analog core stand-in that answers every start with done.
  Assumes starts arrive as one-cycle pulses on ref_clk_i.
*/
module conv_core_model (
  // clock
  input  wire logic        ref_clk_i,
  // request and latency
  input  wire logic        start_i,
  input  wire logic [7:0]  lat_i,
  // answer
  output logic             done_o = 1'b0,
  output logic [15:0]      data_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  // result toggles while none stands, so a stale read shows up
  always @(posedge ref_clk_i) begin
    done_o <= (left == 1);
    data_o <= (left == 1) ? 16'hA5C3 : ~data_o;
    if (start_i) begin
      left <= int'(lat_i);
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
endmodule : conv_core_model

/* verif/adc_trigger_command_control_sva.sv */
/*
  adc_trigger_command_control_sva: port-level checks of start, command
  fields and power-down handshake. Assumes one clock domain.
*/
module adc_trigger_command_control_sva (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       pd_req_i,
  input wire logic       pd_ack_o,
  input wire logic       conv_start_o,
  input wire logic [4:0] conv_chan_o,
  input wire logic       conv_diff_o,
  input wire logic [4:0] conv_res_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // start, command and power-down checks
  // ----------------------------------------------------------------
  sequence s_start; conv_start_o; endsequence
  sequence s_diff; conv_start_o ##0 conv_diff_o; endsequence
  sequence s_se; conv_start_o ##0 !conv_diff_o; endsequence
  property p_pulse; s_start |=> !conv_start_o; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
  property p_hold; s_start |=> $stable({conv_chan_o, conv_diff_o, conv_res_o}); endproperty
  a_hold: assert property (p_hold) else $error("command fields moved");
  property p_diffres; s_diff |-> conv_res_o != trig_ctrl_pkg::RES_SE_LOW; endproperty
  a_diffres: assert property (p_diffres) else $error("bad differential width");
  property p_seres; s_se |-> conv_res_o != trig_ctrl_pkg::RES_DIFF_LOW; endproperty
  a_seres: assert property (p_seres) else $error("bad single-ended width");
  property p_res; s_start |-> conv_res_o inside {5'h10, 5'h0D, 5'h0C}; endproperty
  a_res: assert property (p_res) else $error("width not 16, 13 or 12");
  property p_chan; s_start |-> conv_chan_o < 5'h14; endproperty
  a_chan: assert property (p_chan) else $error("channel out of range");
  property p_ack; pd_ack_o |-> pd_req_i; endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_busy; s_start |-> !pd_ack_o; endproperty
  a_busy: assert property (p_busy) else $error("ack during conversion");
  property p_stay; pd_ack_o && pd_req_i |=> pd_ack_o || !pd_req_i; endproperty
  a_stay: assert property (p_stay) else $error("accept after ack");
endmodule : adc_trigger_command_control_sva
bind adc_trigger_command_control adc_trigger_command_control_sva chk (.ref_clk_i, .reset_i,
  .pd_req_i, .pd_ack_o, .conv_start_o, .conv_chan_o, .conv_diff_o, .conv_res_o);

/* verif/adc_trigger_command_control_test.sv */
/*
  adc_trigger_command_control_test: directed scenarios over APB, timer lines
  and power requests. Assumes the core model and the checker compile first.
*/
module adc_trigger_command_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, sleep_i = 1'b0, clk_runs_in_sleep_i = 1'b0, pd_req_i = 1'b0;
  logic        pready_o, pslverr_o, pd_ack_o, conv_start_o, conv_side_b_o, conv_diff_o;
  logic        conv_dual_o, cal_busy_o, conv_done_i, err;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [4:0]  timer_match_ch3_i = 5'h00, conv_chan_o, conv_res_o;
  logic [15:0] conv_data_i, cal_value_o;
  logic [7:0]  lat = 8'h04;
  int          n_fail = 0, comparisons = 0, n, cyc;
  // free-running module clock
  always #5 ref_clk_i = ~ref_clk_i;
  adc_trigger_command_control uut (.*);
  conv_core_model core (.ref_clk_i, .start_i(conv_start_o), .lat_i(lat),
    .done_o(conv_done_i), .data_o(conv_data_i));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one transfer; a spare edge after release keeps drivers apart
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, d};
    @(posedge ref_clk_i) penable_i <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) begin
        {rd, err} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
        @(posedge ref_clk_i);
        return;
      end
    end
    $display("BAD pready expected 1 seen 0");
    n_fail++;
    conclude();
  endtask : apb
  task automatic wait_start(output int c);
    for (c = 0; conv_start_o !== 1'b1; c++) begin
      @(posedge ref_clk_i);
      if (c > 300) begin
        $display("BAD start expected 1 seen 0");
        n_fail++;
        conclude();
      end
    end
  endtask : wait_start
  task automatic count_starts(int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge ref_clk_i);
      if (conv_start_o === 1'b1) c++;
    end
  endtask : count_starts
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(0, trig_ctrl_pkg::CALAVG_OFFS, 0);
    check("cal count", {24'h0, trig_ctrl_pkg::CAL_AVG_RESET}, rd);
    apb(0, 12'hFFC, 0);
    check("unmapped err", 1, err);
    apb(1, 12'h040, 32'h0000_0205);
    apb(1, 12'h044, 32'h0000_0413);
    apb(1, 12'h048, 32'h0000_0807);
    apb(1, 12'h04C, 32'h0000_071F);
    apb(1, 12'h020, 32'h0001_0000);
  endtask : t_regs
  task automatic t_soft;
    apb(1, 12'h000, 32'h5);
    apb(1, 12'h008, 32'h1);
    wait_start(cyc);
    check("fast start", 2, cyc);
    check("chan", 19, conv_chan_o);
    check("res", trig_ctrl_pkg::RES_HIGH, conv_res_o);
    repeat (8) @(posedge ref_clk_i);
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h008, 32'h1);
    wait_start(cyc);
    check("slow start", trig_ctrl_pkg::STARTUP_CYC + 2, cyc);
    repeat (8) @(posedge ref_clk_i);
  endtask : t_soft
  task automatic t_prio;
    apb(1, 12'h000, 32'h5);
    apb(1, 12'h024, 32'h0000_0300);
    apb(1, 12'h028, 32'h0002_0100);
    apb(1, 12'h008, 32'h6);
    wait_start(cyc);
    check("first chan", 5, conv_chan_o);
    check("diff res", trig_ctrl_pkg::RES_DIFF_LOW, conv_res_o);
    @(posedge ref_clk_i);
    wait_start(cyc);
    check("second chan", 7, conv_chan_o);
    check("se res", trig_ctrl_pkg::RES_SE_LOW, conv_res_o);
    check("dual", 1, conv_dual_o);
    repeat (8) @(posedge ref_clk_i);
  endtask : t_prio
  // every timer code, each line held high to show one event per edge
  task automatic t_hw;
    apb(1, 12'h02C, 32'h0003_0001);
    for (int k = 0; k < 5; k++) begin
      apb(1, 12'h010, {2'b00, trig_ctrl_pkg::SEL_TIMER0 + 6'(k), 24'h0});
      timer_match_ch3_i <= 5'(1 << k);
      wait_start(cyc);
      check("sync delay", 1, cyc >= 3);
      check("side b", 1, conv_side_b_o);
      check("chan map", 0, conv_chan_o);
      count_starts(40, n);
      check("one per edge", 0, n);
      timer_match_ch3_i <= 5'h00;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask : t_hw
  task automatic t_cal;
    apb(1, 12'h00C, 32'h2);
    apb(1, 12'h000, 32'hD);
    apb(1, 12'h008, 32'h1);
    count_starts(20, n);
    check("cal busy", 1, cal_busy_o);
    apb(1, 12'h008, 32'h1);
    count_starts(20, n);
    check("cal value", 16'hA5C3, cal_value_o);
  endtask : t_cal
  task automatic t_power;
    apb(1, 12'h000, 32'h7);
    lat <= 8'd30;
    apb(1, 12'h008, 32'h1);
    wait_start(cyc);
    pd_req_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check("ack while busy", 0, pd_ack_o);
    count_starts(40, n);
    check("ack after done", 1, pd_ack_o);
    lat <= 8'd4;
    apb(1, 12'h008, 32'h1);
    count_starts(30, n);
    check("held in pd", 0, n);
    pd_req_i <= 1'b0;
    count_starts(40, n);
    check("served after pd", 1, n);
    {sleep_i, clk_runs_in_sleep_i} <= 2'b11;
    apb(1, 12'h008, 32'h1);
    count_starts(30, n);
    check("halted", 0, n);
    apb(1, 12'h000, 32'h5);
    count_starts(40, n);
    check("doze off", 1, n);
    clk_runs_in_sleep_i <= 1'b0;
    apb(1, 12'h008, 32'h1);
    count_starts(30, n);
    check("no clock", 0, n);
  endtask : t_power
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_soft();
    t_prio();
    t_hw();
    t_cal();
    t_power();
    conclude();
  end
endmodule : adc_trigger_command_control_test
